// *** core/gdcr_defs.svh ***
`ifndef GDCR_DEFS_SVH
`define GDCR_DEFS_SVH

// Register indices; byte address is four times the index
`define GDCR_IDX_CFG1 10'h0AC
`define GDCR_IDX_CFG2 10'h0AE
`define GDCR_IDX_STAT 10'h0B0
`define GDCR_IDX_CLR 10'h0B1
`define GDCR_IDX_EN 10'h0B2
`define GDCR_IDX_CTRL 10'h0B3

// Reset values
`define GDCR_RST_CFG1 32'h10228100
`define GDCR_RST_CFG2 32'h01200000

// Field positions, first configuration word
`define GDCR_SLEW_LSB 26
`define GDCR_SUPPLY_OVERVOLT_LEVEL_SEL_BIT 19
`define GDCR_SUPPLY_OVERVOLT_PROTECT_EN_BIT 18
`define GDCR_OVERTEMP_WARN_REPORT_EN_BIT 16
`define GDCR_DEG_LSB 12
`define GDCR_OVERCURRENT_TRIP_LEVEL_BIT 10
`define GDCR_MODE_LSB 8
`define GDCR_GAIN_LSB 0

// Field positions, second configuration word
`define GDCR_SEQ_OFF_BIT 24
`define GDCR_REGULATOR_CURRENT_LIMIT_SEL_BIT 23
`define GDCR_VSEL_LSB 21
`define GDCR_MINON_LSB 17

// Control register bits
`define GDCR_CTRL_AUTO_GAIN_BIT 0
`define GDCR_CTRL_FAULT_CLR_BIT 1
`define GDCR_CTRL_FAULT_STATE_BIT 8

// Event bits of status, clear and enable registers
`define GDCR_EV_OCP 0
`define GDCR_EV_OVP 1
`define GDCR_EV_OTW 2
`define GDCR_EV_W 3

// Slew and minimum on-time codes
`define GDCR_SLEW_125 2'h2
`define GDCR_SLEW_200 2'h3
`define GDCR_MINON_AUTO 3'h1
`define GDCR_MINON_0P5 3'h2
`define GDCR_MINON_0P75 3'h3
`define GDCR_MINON_1P0 3'h4

// Timing
`define GDCR_CLK_MHZ 250
`define GDCR_DEG0_NS 200
`define GDCR_DEG1_NS 600
`define GDCR_DEG2_NS 1100
`define GDCR_DEG3_NS 1600
`define GDCR_NS_TO_CYC(ns) ((((ns) * `GDCR_CLK_MHZ) + 999) / 1000)
`define GDCR_RETRY_MS 500
`define GDCR_RETRY_CYC (`GDCR_RETRY_MS * `GDCR_CLK_MHZ * 1000)

`endif

// *** core/gdcr_deglitch.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gdcr_defs.svh"

module gdcr_deglitch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic trip,
    input wire logic [1:0] sel,
    output logic accept_pulse
);
    import gdcr_pkg::*;

    // Cycles a trip must persist, per deglitch code
    function automatic logic [8:0] deg_need(input logic [1:0] code);
        unique case (code)
            2'h0: deg_need = 9'(`GDCR_NS_TO_CYC(`GDCR_DEG0_NS));
            2'h1: deg_need = 9'(`GDCR_NS_TO_CYC(`GDCR_DEG1_NS));
            2'h2: deg_need = 9'(`GDCR_NS_TO_CYC(`GDCR_DEG2_NS));
            2'h3: deg_need = 9'(`GDCR_NS_TO_CYC(`GDCR_DEG3_NS));
        endcase
    endfunction : deg_need

    logic [8:0] cnt; // Consecutive trip cycles, saturating
    wire [8:0] need = deg_need(sel);
    wire reached = trip && ((cnt + 9'h001) == need);

    // Count persistence; one pulse when the need is first met
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 9'h000;
            accept_pulse <= 1'b0;
        end else if (ce) begin
            accept_pulse <= reached; // see [RQ5]
            if (!trip) begin
                cnt <= 9'h000;
            end else if (cnt < need) begin
                cnt <= cnt + 9'h001;
            end
        end
    end
endmodule : gdcr_deglitch
`default_nettype wire

// *** core/gdcr_ocp_fault.sv ***
`timescale 1ns/100ps
`default_nettype none

module gdcr_ocp_fault #(
    parameter logic [31:0] RETRY_CYCLES = 32'd125000000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic accept_pulse,
    input wire gdcr_pkg::gdcr_overcurrent_response_mode_type mode,
    input wire logic clear_req,
    output logic fault
);
    import gdcr_pkg::*;

    gdcr_fault_state_type state; // Fault state
    logic [31:0] timer; // Retry countdown

    // Latched faults wait for software; retrying ones time out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= GDCR_F_IDLE;
            timer <= 32'h0000_0000;
        end else if (ce) begin
            unique case (state)
                GDCR_F_IDLE: begin
                    if (accept_pulse && mode == GDCR_OCP_RETRY) begin
                        state <= GDCR_F_RETRY; // see [RQ8]
                        timer <= RETRY_CYCLES - 32'h0000_0001;
                    end else if (accept_pulse) begin
                        // Undefined codes fall back to latching, the safer side
                        state <= GDCR_F_LATCHED; // see [RQ7]
                    end
                end
                GDCR_F_LATCHED: begin
                    if (clear_req) begin
                        state <= GDCR_F_IDLE; // see [RQ7]
                    end
                end
                GDCR_F_RETRY: begin
                    if (timer == 32'h0000_0000) begin
                        state <= GDCR_F_IDLE; // see [RQ8]
                    end else begin
                        timer <= timer - 32'h0000_0001;
                    end
                end
                default: state <= GDCR_F_IDLE;
            endcase
        end
    end

    assign fault = (state != GDCR_F_IDLE);
endmodule : gdcr_ocp_fault
`default_nettype wire

// *** core/gdcr_pkg.sv ***
package gdcr_pkg;

    // Overcurrent response mode codes
    typedef enum logic [1:0] {
        GDCR_OCP_LATCH = 2'b00,
        GDCR_OCP_RETRY = 2'b01,
        GDCR_OCP_UNDEF2 = 2'b10,
        GDCR_OCP_UNDEF3 = 2'b11
    } gdcr_overcurrent_response_mode_type;

    // Overcurrent fault states
    typedef enum logic [1:0] {
        GDCR_F_IDLE = 2'b00,
        GDCR_F_LATCHED = 2'b01,
        GDCR_F_RETRY = 2'b10
    } gdcr_fault_state_type;

endpackage : gdcr_pkg

// *** core/gdcr_regs.sv ***
// Operation
// [RQ1] Slew code 2 is 125, 3 is 200
// [RQ2] Overvoltage level: clear 34 V, set 22 V
// [RQ3] Overvoltage protection active only when enabled
// [RQ4] Overtemperature warning drives fault pin only if enabled
// [RQ5] Overcurrent must persist deglitch time before accepted
// [RQ6] Trip level: clear 16 A, set 24 A
// [RQ7] Mode 0: overcurrent fault latches until cleared
// [RQ8] Mode 1: fault self-clears, retries after 500 ms
// [RQ9] Gain code selects 0.15 to 1.2 V/A
// [RQ10] Static gain ignored while automatic gain enabled
// [RQ11] Sequencing-off bit resets set, write one clears
// [RQ12] Regulator limit: clear 600 mA, set 150 mA
// [RQ13] Regulator voltage code, reset code 1 (5.0 V)
// [RQ14] Minimum on-time code 1 derives from slew
// [RQ15] Software writes reserved fields back at reset values

`timescale 1ns/100ps
`default_nettype none
`include "gdcr_defs.svh"

module gdcr_regs #(
    parameter logic [31:0] RETRY_CYCLES = 32'(`GDCR_RETRY_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic overcurrent_raw,
    input wire logic overtemp_warn_raw,
    input wire logic supply_overvolt_raw,
    input wire logic [1:0] auto_gain_code,
    output logic [1:0] slew_rate_sel,
    output logic supply_overvolt_level_sel,
    output logic supply_overvolt_protect_en,
    output logic overcurrent_trip_level,
    output logic [1:0] sense_amp_gain_sel,
    output logic regulator_sequencing_off,
    output logic regulator_current_limit_sel,
    output logic [1:0] regulator_voltage_sel,
    output logic [2:0] low_side_min_on_sel,
    output logic overcurrent_fault,
    output logic fault_indicator_n,
    output logic irq
);
    import gdcr_pkg::*;

    // Minimum on-time resolved
    // from its code and the slew setting
    function automatic logic [2:0] min_on_resolve(
        input logic [2:0] code,
        input logic [1:0] slew
    );
        logic [2:0] res;

        res = code;
        if (code == `GDCR_MINON_AUTO) begin
            // Slower edges need a longer
            // low-side on-time to settle
            unique case (slew)
                `GDCR_SLEW_200: res = `GDCR_MINON_0P5;
                `GDCR_SLEW_125: res = `GDCR_MINON_0P75;
                default: res = `GDCR_MINON_1P0;
            endcase
        end
        min_on_resolve = res;
    endfunction : min_on_resolve

    // Register storage
    logic [31:0] cfg1; // First configuration word
    logic [31:0] cfg2; // Second configuration word
    logic [`GDCR_EV_W-1:0] ev_status; // Sticky events
    logic [`GDCR_EV_W-1:0] ev_enable; // Event enables
    logic auto_gain_en; // Automatic gain selection on
    logic fault_clr; // One-cycle fault clear from software

    // Edge history for event detection
    // Both reset low, the pins' idle level
    logic ovp_trip_d; // Previous gated overvoltage
    logic otw_d; // Previous overtemperature warning

    // Bus phase decode
    // Byte lane bits are ignored
    wire setup_phase = psel && !penable;
    wire access_done = psel && penable && pready;
    wire wr_done = access_done && pwrite;
    wire [9:0] idx = paddr[11:2];

    // Address decode
    wire hit_cfg1 = (idx == `GDCR_IDX_CFG1);
    wire hit_cfg2 = (idx == `GDCR_IDX_CFG2);
    wire hit_stat = (idx == `GDCR_IDX_STAT);
    wire hit_clr = (idx == `GDCR_IDX_CLR);
    wire hit_en = (idx == `GDCR_IDX_EN);
    wire hit_ctrl = (idx == `GDCR_IDX_CTRL);
    wire hit_any = hit_cfg1
        || hit_cfg2
        || hit_stat
        || hit_clr
        || hit_en
        || hit_ctrl;

    // Write strobes, taken
    // only at the completing edge
    wire wr_cfg1 = wr_done && hit_cfg1;
    wire wr_cfg2 = wr_done && hit_cfg2;
    wire wr_clr = wr_done && hit_clr;
    wire wr_en = wr_done && hit_en;
    wire wr_ctrl = wr_done && hit_ctrl;

    // Field views of the first word
    // Slew codes 0 and 1 are undefined
    wire [1:0] f_slew = cfg1[`GDCR_SLEW_LSB +: 2];
    wire f_supply_overvolt_level_sel = cfg1[`GDCR_SUPPLY_OVERVOLT_LEVEL_SEL_BIT];
    wire f_supply_overvolt_protect_en = cfg1[`GDCR_SUPPLY_OVERVOLT_PROTECT_EN_BIT];
    wire f_overtemp_warn_report_en = cfg1[`GDCR_OVERTEMP_WARN_REPORT_EN_BIT];
    wire [1:0] f_deg = cfg1[`GDCR_DEG_LSB +: 2];
    wire f_overcurrent_trip_level = cfg1[`GDCR_OVERCURRENT_TRIP_LEVEL_BIT];
    wire [1:0] f_mode = cfg1[`GDCR_MODE_LSB +: 2];
    wire [1:0] f_gain = cfg1[`GDCR_GAIN_LSB +: 2];

    // Field views of the second word
    wire f_seq_off = cfg2[`GDCR_SEQ_OFF_BIT];
    wire f_regulator_current_limit_sel = cfg2[`GDCR_REGULATOR_CURRENT_LIMIT_SEL_BIT];
    wire [1:0] f_vsel = cfg2[`GDCR_VSEL_LSB +: 2];
    wire [2:0] f_minon = cfg2[`GDCR_MINON_LSB +: 3];

    // Second word write
    // Sequencing-off is write-one-to-clear
    wire next_seq_off = f_seq_off && !pwdata[`GDCR_SEQ_OFF_BIT]; // see [RQ11]
    wire [31:0] next_cfg2 = {
        pwdata[31:`GDCR_SEQ_OFF_BIT+1],
        next_seq_off,
        pwdata[`GDCR_SEQ_OFF_BIT-1:0]
    };

    // Fault engine outputs
    wire ocp_accept; // Deglitched overcurrent, one pulse
    wire ocp_fault_now; // Overcurrent fault state

    // Event sources; overvoltage gated by its enable, warning ungated
    wire ovp_trip = f_supply_overvolt_protect_en && supply_overvolt_raw; // see [RQ3]
    wire ev_ovp = ovp_trip && !ovp_trip_d;
    wire ev_otw = overtemp_warn_raw && !otw_d;

    // Event vector and sticky update
    // A new event beats a same-cycle clear
    wire [`GDCR_EV_W-1:0] ev_set = {
        ev_otw,
        ev_ovp,
        ocp_accept
    };
    wire [`GDCR_EV_W-1:0] ev_clr = wr_clr
        ? pwdata[`GDCR_EV_W-1:0]
        : {`GDCR_EV_W{1'b0}};
    wire [`GDCR_EV_W-1:0] next_ev_status = (ev_status & ~ev_clr) | ev_set;

    // Control readback
    // Fault state is live
    wire [31:0] ctrl_rd = (32'(auto_gain_en) << `GDCR_CTRL_AUTO_GAIN_BIT)
                        | (32'(ocp_fault_now) << `GDCR_CTRL_FAULT_STATE_BIT);

    // Read data selection
    // Clear register reads as zero
    wire [31:0] rd_mux = hit_cfg1 ? cfg1 :
                         hit_cfg2 ? cfg2 :
                         hit_stat ? 32'(ev_status) :
                         hit_en ? 32'(ev_enable) :
                         hit_ctrl ? ctrl_rd :
                         32'h0000_0000;

    // Effective gain: static field
    // only while automatic selection is off
    wire [1:0] next_gain = auto_gain_en
        ? auto_gain_code
        : f_gain; // see [RQ10]

    // Fault pin low on overcurrent fault,
    // gated overvoltage or reported warning
    wire next_fault_n = !(
        ocp_fault_now
        || ovp_trip
        || (f_overtemp_warn_report_en && overtemp_warn_raw) // see [RQ4]
    );

    // Overcurrent deglitch filter
    // Persistence counted in clock cycles
    gdcr_deglitch u_deglitch (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .trip(overcurrent_raw),
        .sel(f_deg),
        .accept_pulse(ocp_accept)
    );

    // Overcurrent response: latched or timed retry
    gdcr_ocp_fault #(
        .RETRY_CYCLES(RETRY_CYCLES)
    ) u_ocp_fault (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .accept_pulse(ocp_accept),
        .mode(gdcr_overcurrent_response_mode_type'(f_mode)),
        .clear_req(fault_clr),
        .fault(ocp_fault_now)
    );

    // Bus answer: ready one cycle after setup
    // Read data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            pready <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Configuration words; reserved bits stay
    // plain storage so written-back values hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg1 <= `GDCR_RST_CFG1;
            cfg2 <= `GDCR_RST_CFG2; // see [RQ11] [RQ13]
        end else if (ce) begin
            if (wr_cfg1) begin
                cfg1 <= pwdata; // see [RQ15]
            end
            if (wr_cfg2) begin
                cfg2 <= next_cfg2; // see [RQ11]
            end
        end
    end

    // Control register
    // Fault clear is a pulse, reads zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_gain_en <= 1'b0;
            fault_clr <= 1'b0;
        end else if (ce) begin
            fault_clr <= wr_ctrl && pwdata[`GDCR_CTRL_FAULT_CLR_BIT]; // see [RQ7]
            if (wr_ctrl) begin
                auto_gain_en <= pwdata[`GDCR_CTRL_AUTO_GAIN_BIT];
            end
        end
    end

    // Interrupt status, enables
    // and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_status <= {`GDCR_EV_W{1'b0}};
            ev_enable <= {`GDCR_EV_W{1'b0}};
            ovp_trip_d <= 1'b0;
            otw_d <= 1'b0;
        end else if (ce) begin
            ev_status <= next_ev_status;
            ovp_trip_d <= ovp_trip;
            otw_d <= overtemp_warn_raw;
            if (wr_en) begin
                ev_enable <= pwdata[`GDCR_EV_W-1:0];
            end
        end
    end

    // Interrupt output, registered
    // Built from next status to move with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(next_ev_status & ev_enable);
        end
    end

    // Driver settings
    // Each lags its field by one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_rate_sel <= 2'h0;
            supply_overvolt_level_sel <= 1'b0;
            supply_overvolt_protect_en <= 1'b0;
            overcurrent_trip_level <= 1'b0;
            sense_amp_gain_sel <= 2'h0;
        end else if (ce) begin
            slew_rate_sel <= f_slew; // see [RQ1]
            supply_overvolt_level_sel <= f_supply_overvolt_level_sel; // see [RQ2]
            supply_overvolt_protect_en <= f_supply_overvolt_protect_en; // see [RQ3]
            overcurrent_trip_level <= f_overcurrent_trip_level; // see [RQ6]
            sense_amp_gain_sel <= next_gain; // see [RQ9] [RQ10]
        end
    end

    // Regulator settings and minimum on-time
    // Resets mirror the second word's reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_sequencing_off <= 1'b1;
            regulator_current_limit_sel <= 1'b0;
            regulator_voltage_sel <= 2'h1;
            low_side_min_on_sel <= 3'h0;
        end else if (ce) begin
            regulator_sequencing_off <= f_seq_off; // see [RQ11]
            regulator_current_limit_sel <= f_regulator_current_limit_sel; // see [RQ12]
            regulator_voltage_sel <= f_vsel; // see [RQ13]
            low_side_min_on_sel <= min_on_resolve(f_minon, f_slew); // see [RQ14]
        end
    end

    // Fault outputs
    // Pin is active low, so it resets high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overcurrent_fault <= 1'b0;
            fault_indicator_n <= 1'b1;
        end else if (ce) begin
            overcurrent_fault <= ocp_fault_now; // see [RQ7] [RQ8]
            fault_indicator_n <= next_fault_n;
        end
    end
endmodule : gdcr_regs
`default_nettype wire

// *** verification/gdcr_regs_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gdcr_defs.svh"

// Pin-level checks of the configuration bank
module gdcr_regs_props #(
    parameter logic [31:0] RETRY_CYCLES = 32'd20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic overcurrent_raw,
    input wire logic supply_overvolt_raw,
    input wire logic [1:0] slew_rate_sel,
    input wire logic supply_overvolt_level_sel,
    input wire logic supply_overvolt_protect_en,
    input wire logic overcurrent_trip_level,
    input wire logic regulator_sequencing_off,
    input wire logic regulator_current_limit_sel,
    input wire logic [1:0] regulator_voltage_sel,
    input wire logic [2:0] low_side_min_on_sel,
    input wire logic overcurrent_fault,
    input wire logic fault_indicator_n
);
    // Completed writes, decoded per word
    wire wr_ok = psel && penable && pready && pwrite && ce;
    wire w1 = wr_ok && (paddr[11:2] == `GDCR_IDX_CFG1);
    wire w2 = wr_ok && (paddr[11:2] == `GDCR_IDX_CFG2);
    logic [31:0] last_wd; // Data of the latest write
    logic [31:0] fault_len; // Cycles the fault has stood

    // Writes are two cycles apart at least
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_wd <= '0;
            fault_len <= '0;
        end else begin
            if (wr_ok) begin
                last_wd <= pwdata;
            end
            fault_len <= overcurrent_fault ? fault_len + 32'h1 : '0;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_slew; w1 |=> ##1 slew_rate_sel == last_wd[27:26]; endproperty
    a_slew: assert property (p_slew) else $error("slew select wrong");
    property p_ovp_lvl; w1 |=> ##1 supply_overvolt_level_sel == last_wd[19]; endproperty
    a_ovp_lvl: assert property (p_ovp_lvl) else $error("overvolt level wrong");
    property p_ovp_gate;
        supply_overvolt_protect_en && supply_overvolt_raw |=> !fault_indicator_n || !supply_overvolt_protect_en;
    endproperty
    a_ovp_gate: assert property (p_ovp_gate) else $error("overvolt not on pin");
    property p_deglitch; $rose(overcurrent_fault) |-> $past(overcurrent_raw, 4) && $past(overcurrent_raw, 50); endproperty
    a_deglitch: assert property (p_deglitch) else $error("fault without persistence");
    property p_trip; w1 |=> ##1 overcurrent_trip_level == last_wd[10]; endproperty
    a_trip: assert property (p_trip) else $error("trip level wrong");
    property p_seq_hold; !$rose(regulator_sequencing_off); endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("sequencing off set again");
    property p_seq_clr; w2 && pwdata[24] |=> ##1 !regulator_sequencing_off; endproperty
    a_seq_clr: assert property (p_seq_clr) else $error("sequencing off not cleared");
    property p_climit; w2 |=> ##1 regulator_current_limit_sel == last_wd[23]; endproperty
    a_climit: assert property (p_climit) else $error("current limit wrong");
    property p_vsel; w2 |=> ##1 regulator_voltage_sel == last_wd[22:21]; endproperty
    a_vsel: assert property (p_vsel) else $error("regulator voltage wrong");
    property p_minon; low_side_min_on_sel != `GDCR_MINON_AUTO; endproperty
    a_minon: assert property (p_minon) else $error("automatic on-time not resolved");
    property p_ready; psel && !penable && ce |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("ready not a single access pulse");

    // Main scenarios reached
    c_w1: cover property (w1);
    c_clr: cover property (w2 && pwdata[24]);
    c_retry: cover property ($fell(overcurrent_fault) && fault_len >= RETRY_CYCLES && fault_len <= RETRY_CYCLES + 2);
endmodule : gdcr_regs_props

`default_nettype wire

// *** verification/gdcr_regs_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gdcr_defs.svh"

bind gdcr_regs gdcr_regs_props #(.RETRY_CYCLES(RETRY_CYCLES)) u_props (.*);

module gdcr_regs_test;
    localparam int RETRY = 20; // Short retry span keeps the run brief
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic overcurrent_raw = 1'b0, overtemp_warn_raw = 1'b0, supply_overvolt_raw = 1'b0;
    logic [1:0] auto_gain_code = 2'h0;
    logic [31:0] prdata;
    logic pready, pslverr, supply_overvolt_level_sel, supply_overvolt_protect_en, overcurrent_trip_level;
    logic regulator_sequencing_off, regulator_current_limit_sel, overcurrent_fault, fault_indicator_n, irq;
    logic [1:0] slew_rate_sel, sense_amp_gain_sel, regulator_voltage_sel;
    logic [2:0] low_side_min_on_sel;
    int errors = 0;
    int comparisons = 0;

    gdcr_regs #(.RETRY_CYCLES(32'(RETRY))) dut (.*);

    // 4 ns clock
    always #2 pclk = ~pclk;

    // Shared compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One bus transfer, waits for ready
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, wd, rd, err);
        repeat (2) @(posedge pclk); // Let the field outputs land
    endtask : wr

    task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0, rd, err);
        chk(what, exp, rd);
    endtask : rd_chk

    // Word one; fl = {level, protect, report, trip}; reserved ones kept
    function automatic logic [31:0] mk1(input logic [1:0] slew, input logic [3:0] fl, input logic [1:0] deg,
        input logic [1:0] mode, input logic [1:0] gain);
        mk1 = 32'h10228000 | {4'h0, slew, 6'h0, fl[3:2], 1'b0, fl[1], 2'h0, deg, 1'b0, fl[0], mode, 6'h0, gain};
    endfunction : mk1

    task automatic t_reset;
        logic [31:0] rd;
        logic err;
        chk("seq off", 32'h1, regulator_sequencing_off);
        chk("vsel", 32'h1, regulator_voltage_sel);
        rd_chk("cfg1", `GDCR_IDX_CFG1, 32'h10228100);
        rd_chk("cfg2", `GDCR_IDX_CFG2, 32'h01200000);
        apb(1'b0, 10'h000, 32'h0, rd, err);
        chk("unmapped error", 32'h1, err);
        $display("reset test done");
    endtask : t_reset

    task automatic t_fields;
        logic [31:0] v1, v2;
        for (int i = 0; i < 4; i++) begin
            v1 = mk1({1'b1, i[0]}, {i[1], 2'b00, i[0]}, 2'h0, 2'h1, i[1:0]);
            v2 = {8'h00, i[0], i[1:0], 1'b0, 3'h1, 17'h0};
            wr(`GDCR_IDX_CFG1, v1);
            wr(`GDCR_IDX_CFG2, v2);
            rd_chk("cfg1 back", `GDCR_IDX_CFG1, v1);
            rd_chk("cfg2 back", `GDCR_IDX_CFG2, v2 | 32'h01000000);
            chk("slew", {1'b1, i[0]}, slew_rate_sel);
            chk("ovp level", i[1], supply_overvolt_level_sel);
            chk("trip level", i[0], overcurrent_trip_level);
            chk("gain", i[1:0], sense_amp_gain_sel);
            chk("climit", i[0], regulator_current_limit_sel);
            chk("vsel", i[1:0], regulator_voltage_sel);
            chk("min on", i[0] ? 3'h2 : 3'h3, low_side_min_on_sel);
        end
        auto_gain_code <= 2'h1;
        wr(`GDCR_IDX_CTRL, 32'h1);
        chk("auto gain", 32'h1, sense_amp_gain_sel);
        wr(`GDCR_IDX_CTRL, 32'h0);
        chk("static gain", 32'h3, sense_amp_gain_sel);
        wr(`GDCR_IDX_CFG2, 32'h01000000);
        chk("seq on", 32'h0, regulator_sequencing_off);
        $display("field test done");
    endtask : t_fields

    task automatic t_pin;
        wr(`GDCR_IDX_EN, 32'h6);
        supply_overvolt_raw <= 1'b1;
        overtemp_warn_raw <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("pin quiet", 32'h1, fault_indicator_n);
        rd_chk("status", `GDCR_IDX_STAT, 32'h4);
        chk("irq", 32'h1, irq);
        wr(`GDCR_IDX_CLR, 32'h4);
        chk("irq cleared", 32'h0, irq);
        wr(`GDCR_IDX_CFG1, mk1(2'h3, 4'b0100, 2'h0, 2'h1, 2'h0));
        chk("pin ovp", 32'h0, fault_indicator_n);
        chk("supply_overvolt_protect_en", 32'h1, supply_overvolt_protect_en);
        wr(`GDCR_IDX_EN, 32'h0);
        chk("irq masked", 32'h0, irq);
        supply_overvolt_raw <= 1'b0;
        wr(`GDCR_IDX_CFG1, mk1(2'h3, 4'b0010, 2'h0, 2'h1, 2'h0));
        chk("pin warn", 32'h0, fault_indicator_n);
        $display("pin test done");
    endtask : t_pin

    task automatic t_ocp;
        int ns[4] = '{200, 600, 1100, 1600};
        int n, k;
        overtemp_warn_raw <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            n = ns[c] / 4;
            wr(`GDCR_IDX_CFG1, mk1(2'h3, 4'b0000, c[1:0], c == 3 ? 2'h2 : 2'h0, 2'h0));
            overcurrent_raw <= 1'b1;
            repeat (n - 2) @(posedge pclk);
            overcurrent_raw <= 1'b0;
            repeat (6) @(posedge pclk);
            chk("short burst", 32'h0, overcurrent_fault);
            overcurrent_raw <= 1'b1;
            k = 0;
            while (overcurrent_fault !== 1'b1 && k < 600) begin
                @(posedge pclk);
                k++;
            end
            chk("deglitch span", 32'h1, k >= n && k <= n + 4);
            overcurrent_raw <= 1'b0;
            repeat (10) @(posedge pclk);
            chk("latched", 32'h1, overcurrent_fault);
            wr(`GDCR_IDX_CTRL, 32'h2);
            chk("cleared", 32'h0, overcurrent_fault);
        end
        wr(`GDCR_IDX_CFG1, mk1(2'h3, 4'b0000, 2'h0, 2'h1, 2'h0));
        overcurrent_raw <= 1'b1;
        while (overcurrent_fault !== 1'b1) @(posedge pclk);
        overcurrent_raw <= 1'b0;
        k = 0;
        while (overcurrent_fault === 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk("retry span", 32'h1, k >= RETRY && k <= RETRY + 3);
        $display("overcurrent test done");
    endtask : t_ocp

    // Verdict and end of run
    task automatic summarize;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_fields();
        t_pin();
        t_ocp();
        summarize();
    end

    // Hang guard, far past the tests' length
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("watchdog expired");
        summarize();
    end
endmodule : gdcr_regs_test

`default_nettype wire
